// >>> qei_pkg.sv
`default_nettype none
package qei_pkg;
    // ****************************************
    // geometry and timing
    // ****************************************
    localparam int          NUM_CHANNELS      = 4;
    localparam int          REF_CLK_HZ        = 50000000;
    localparam int          WHOLE_BITS        = 24;
    localparam int          FINE_BITS         = 12;
    localparam int          COARSE_BITS       = 8;
    localparam int          TIMER_BITS        = 16;
    // ****************************************
    // register map
    // ****************************************
    localparam logic [11:0] DIVIDERS_OFFSET   = 12'h000;
    localparam logic [11:0] CHANNEL_BASE      = 12'h100;
    localparam int          CHANNEL_SHIFT     = 5;
    localparam logic [4:0]  CONTROL_OFFSET    = 5'h00;
    localparam logic [4:0]  STATUS_OFFSET     = 5'h04;
    localparam logic [4:0]  SERVO_OFFSET      = 5'h08;
    localparam logic [4:0]  PHASE_OFFSET      = 5'h0C;
    localparam logic [4:0]  TRIGGER_OFFSET    = 5'h10;
    localparam logic [4:0]  FINE_SERVO_OFFSET = 5'h14;
    localparam logic [4:0]  FINE_TRIG_OFFSET  = 5'h18;
    // ****************************************
    // field layout and reset values
    // ****************************************
    localparam int          SAMPLE_DIV_LSB    = 0;
    localparam int          FILTER_DIV_LSB    = 4;
    localparam logic [3:0]  SAMPLE_DIV_RESET  = 4'h5;
    localparam logic [3:0]  FILTER_DIV_RESET  = 4'h4;
    localparam int          CTRL_FRAC_LSB     = 4;
    localparam int          CTRL_ATAN_BIT     = 8;
    localparam logic [3:0]  DECODE_RESET      = 4'h3;
    localparam logic [3:0]  FRAC_SEL_RESET    = 4'h0;
    localparam int          STAT_FAULT_BIT    = 0;
    localparam int          STAT_A_BIT        = 1;
    localparam int          STAT_B_BIT        = 2;
    localparam int          STAT_DIR_BIT      = 3;
    // low two bits of decode_control pick counts per line, bit 2 the sense
    localparam logic [1:0]  MODE_OFF          = 2'h0;
    localparam logic [1:0]  MODE_X1           = 2'h1;
    localparam logic [1:0]  MODE_X2           = 2'h2;
    localparam logic [1:0]  MODE_X4           = 2'h3;
    localparam int          SENSE_BIT         = 2;

    typedef struct packed {
        logic       arctangent_extension_enable;
        logic [3:0] fraction_source_select;
        logic [3:0] decode_control;
    } channel_ctrl_t;

    typedef struct packed {
        logic a;
        logic b;
        logic trigger;
    } channel_pins_t;
endpackage : qei_pkg
`default_nettype wire

// >>> quadrature_encoder_interface.sv
`default_nettype none
module quadrature_encoder_interface
    import qei_pkg::*;
#(
    parameter int NCH = NUM_CHANNELS
)(
    // clock and reset
    input  wire logic                 REF_CLK,
    input  wire logic                 RESET,
    // apb slave
    input  wire logic                 PSEL,
    input  wire logic                 PENABLE,
    input  wire logic                 PWRITE,
    input  wire logic [11:0]          PADDR,
    input  wire logic [31:0]          PWDATA,
    output logic      [31:0]          PRDATA,
    output logic                      PREADY,
    output logic                      PSLVERR,
    // system clocks from the backplane
    input  wire logic                 SERVO_CLOCK,
    input  wire logic                 PHASE_CLOCK,
    // encoder and trigger pins, one set per channel
    input  wire channel_pins_t [NCH-1:0] ENCODER,
    // arctangent fraction from a sinusoidal path, 12 bits per channel
    input  wire logic [NCH*FINE_BITS-1:0] ARCTANGENT_FRACTION
);
    // ****************************************
    // dividers and sampling enables
    // ****************************************
    logic [3:0]  sampling_divider;
    logic [3:0]  secondary_filter_divider;
    logic [14:0] sample_count;
    logic [14:0] filter_count;
    logic        sample_tick;
    logic        filter_tick;
    logic [14:0] sample_mask;
    logic [14:0] filter_mask;

    // a divide by 2^n wraps a free counter under an n-bit mask
    assign sample_mask = 15'((32'd1 << sampling_divider) - 32'd1);
    assign filter_mask = 15'((32'd1 << secondary_filter_divider) - 32'd1);
    assign sample_tick = (sample_count & sample_mask) == 15'h0000;
    assign filter_tick = sample_tick && ((filter_count & filter_mask) == 15'h0000);

    always_ff @(posedge REF_CLK or posedge RESET)
    begin
        if (RESET)
            sample_count <= 15'h0000;
        else
            sample_count <= sample_count + 15'h0001;
    end

    always_ff @(posedge REF_CLK or posedge RESET)
    begin
        if (RESET)
            filter_count <= 15'h0000;
        else if (sample_tick)
            filter_count <= filter_count + 15'h0001;
    end

    // ****************************************
    // servo and phase clock synchronisers
    // ****************************************
    logic [1:0] clk_meta;
    logic [1:0] clk_sync;
    logic [1:0] clk_last;
    logic       servo_event;
    logic       phase_event;

    always_ff @(posedge REF_CLK or posedge RESET)
    begin
        if (RESET)
        begin
            clk_meta <= 2'h0;
            clk_sync <= 2'h0;
            clk_last <= 2'h0;
        end
        else
        begin
            clk_meta <= {SERVO_CLOCK, PHASE_CLOCK};
            clk_sync <= clk_meta;
            clk_last <= clk_sync;
        end
    end

    assign servo_event = clk_sync[1] & ~clk_last[1];
    assign phase_event = clk_sync[0] & ~clk_last[0];

    // ****************************************
    // bus decode
    // ****************************************
    logic        setup;
    logic        wr_access;
    logic [2:0]  reg_sel;
    logic [1:0]  ch_sel;
    logic        ch_space;
    logic [31:0] rd_word [NCH];
    logic        ch_hit;

    assign setup     = PSEL && !PENABLE;
    assign wr_access = PSEL && PENABLE && PWRITE;
    assign ch_space  = (PADDR[11:8] == CHANNEL_BASE[11:8])
                       && (PADDR[7:CHANNEL_SHIFT] < 3'(NCH));
    assign ch_sel    = PADDR[CHANNEL_SHIFT+1:CHANNEL_SHIFT];
    assign reg_sel   = PADDR[4:2];
    assign ch_hit    = ch_space && (PADDR[4:0] <= FINE_TRIG_OFFSET) && (PADDR[1:0] == 2'h0);
    assign PREADY    = 1'b1;
    // zero wait: read data was caught during setup
    assign PSLVERR   = PSEL && PENABLE && !ch_hit && (PADDR != DIVIDERS_OFFSET);

    always_ff @(posedge REF_CLK or posedge RESET)
    begin
        if (RESET)
        begin
            sampling_divider         <= SAMPLE_DIV_RESET;
            secondary_filter_divider <= FILTER_DIV_RESET;
        end
        else if (wr_access && PADDR == DIVIDERS_OFFSET)
        begin
            sampling_divider         <= PWDATA[SAMPLE_DIV_LSB+3:SAMPLE_DIV_LSB];
            secondary_filter_divider <= PWDATA[FILTER_DIV_LSB+3:FILTER_DIV_LSB];
        end
    end

    always_ff @(posedge REF_CLK or posedge RESET)
    begin
        if (RESET)
            PRDATA <= 32'h0000_0000;
        else if (setup)
        begin
            if (PADDR == DIVIDERS_OFFSET)
                PRDATA <= {24'h000000, secondary_filter_divider, sampling_divider};
            else if (ch_hit)
                PRDATA <= rd_word[ch_sel];
            else
                PRDATA <= 32'h0000_0000;
        end
    end

    // ****************************************
    // per-channel decoder and latches
    // ****************************************
    for (genvar ch = 0; ch < NCH; ch++)
    begin : g_channel
        channel_ctrl_t             ctrl;
        logic [2:0]                pin_meta;
        logic [2:0]                pin_sync;
        logic [1:0]                hist_a;
        logic [1:0]                hist_b;
        logic                      filt_a;
        logic                      filt_b;
        logic [1:0]                trig_hist;
        logic                      trig_filt;
        logic                      trig_last;
        logic                      trig_event;
        logic                      fault;
        logic                      dir_up;
        logic [WHOLE_BITS-1:0]     count;
        logic                      next_a;
        logic                      next_b;
        logic                      edge_a;
        logic                      edge_b;
        logic                      step;
        logic                      step_up;
        logic [TIMER_BITS-1:0]     since;
        logic [TIMER_BITS-1:0]     period;
        logic [FINE_BITS-1:0]      timer_frac;
        logic [FINE_BITS-1:0]      frac;
        logic [31:0]               fine_pos;
        logic [31:0]               coarse_pos;
        logic [31:0]               servo_latch;
        logic [31:0]               phase_latch;
        logic [31:0]               trigger_latch;
        logic [31:0]               fine_servo_latch;
        logic [31:0]               fine_trigger_latch;
        logic                      ctrl_wr;
        logic                      stat_wr;

        assign ctrl_wr = wr_access && ch_hit && ch_sel == 2'(ch) && PADDR[4:0] == CONTROL_OFFSET;
        assign stat_wr = wr_access && ch_hit && ch_sel == 2'(ch) && PADDR[4:0] == STATUS_OFFSET;

        always_ff @(posedge REF_CLK or posedge RESET)
        begin
            if (RESET)
                ctrl <= '{1'b0, FRAC_SEL_RESET, DECODE_RESET};
            else if (ctrl_wr)
                ctrl <= '{PWDATA[CTRL_ATAN_BIT],
                          PWDATA[CTRL_FRAC_LSB+3:CTRL_FRAC_LSB], PWDATA[3:0]};
        end

        always_ff @(posedge REF_CLK or posedge RESET)
        begin
            if (RESET)
            begin
                pin_meta <= 3'h0;
                pin_sync <= 3'h0;
            end
            else
            begin
                pin_meta <= ENCODER[ch];
                pin_sync <= pin_meta;
            end
        end

        // delay filter: a level is taken once two samples agree, so a spike
        // shorter than one sampling period never reaches the decoder
        always_ff @(posedge REF_CLK or posedge RESET)
        begin
            if (RESET)
            begin
                hist_a <= 2'h0;
                hist_b <= 2'h0;
                filt_a <= 1'b0;
                filt_b <= 1'b0;
            end
            else if (sample_tick)
            begin
                hist_a <= {hist_a[0], pin_sync[2]};
                hist_b <= {hist_b[0], pin_sync[1]};
                if (hist_a[1] == hist_a[0])
                    filt_a <= hist_a[0];
                if (hist_b[1] == hist_b[0])
                    filt_b <= hist_b[0];
            end
        end

        // trigger passes the secondary filter, ticking at the sample rate or slower, before its edge is used
        always_ff @(posedge REF_CLK or posedge RESET)
        begin
            if (RESET)
            begin
                trig_hist <= 2'h0;
                trig_filt <= 1'b0;
                trig_last <= 1'b0;
            end
            else
            begin
                trig_last <= trig_filt;
                if (filter_tick)
                begin
                    trig_hist <= {trig_hist[0], pin_sync[0]};
                    if (trig_hist[1] == trig_hist[0])
                        trig_filt <= trig_hist[0];
                end
            end
        end

        assign trig_event = trig_filt & ~trig_last;

        assign next_a = (hist_a[1] == hist_a[0]) ? hist_a[0] : filt_a;
        assign next_b = (hist_b[1] == hist_b[0]) ? hist_b[0] : filt_b;
        assign edge_a = sample_tick && (next_a != filt_a);
        assign edge_b = sample_tick && (next_b != filt_b);

        // A leading B counts up in the base sense; bit 2 flips it
        always_comb
        begin
            step    = 1'b0;
            step_up = (edge_a ? (next_a != filt_b) : (next_b == filt_a))
                      ^ ctrl.decode_control[SENSE_BIT];
            unique case (ctrl.decode_control[1:0])
                MODE_X4: step = edge_a ^ edge_b;
                MODE_X2: step = edge_a && !edge_b;
                MODE_X1: step = edge_a && !edge_b && !filt_b;
                MODE_OFF: step = 1'b0;
            endcase
        end

        always_ff @(posedge REF_CLK or posedge RESET)
        begin
            if (RESET)
            begin
                count  <= '0;
                dir_up <= 1'b1;
            end
            else if (step)
            begin
                count  <= step_up ? count + 1'b1 : count - 1'b1;
                dir_up <= step_up;
            end
        end

        // sticky; a fresh fault wins over a clear in the same cycle
        always_ff @(posedge REF_CLK or posedge RESET)
        begin
            if (RESET)
                fault <= 1'b0;
            else if (edge_a && edge_b)
                fault <= 1'b1;
            else if (stat_wr && PWDATA[STAT_FAULT_BIT])
                fault <= 1'b0;
        end

        // 1/T timers: clocks since the last step and length of the last gap
        always_ff @(posedge REF_CLK or posedge RESET)
        begin
            if (RESET)
            begin
                since  <= '0;
                period <= '1;
            end
            else if (step)
            begin
                since  <= '0;
                period <= since;
            end
            else if (since != '1)
                since <= since + 1'b1;
        end

        // a gap longer than the last one pins the estimate just short of a count
        always_comb
        begin
            if (period == '0 || since >= period)
                timer_frac = '1;
            else
                timer_frac = FINE_BITS'(({since, {FINE_BITS{1'b0}}}) / period);
        end

        always_comb
        begin
            if (ctrl.arctangent_extension_enable)
                frac = ARCTANGENT_FRACTION[ch*FINE_BITS +: FINE_BITS];
            else
                frac = timer_frac;
        end

        always_comb
        begin
            if (ctrl.fraction_source_select != FRAC_SEL_RESET)
            begin
                fine_pos   = {count[19:0], {FINE_BITS{1'b0}}};
                coarse_pos = {count, {COARSE_BITS{1'b0}}};
            end
            else if (dir_up)
            begin
                fine_pos   = {count[19:0], frac};
                coarse_pos = {count, frac[FINE_BITS-1 -: COARSE_BITS]};
            end
            else
            begin
                fine_pos   = {count[19:0], {FINE_BITS{1'b0}}} - 32'(frac);
                coarse_pos = {count, {COARSE_BITS{1'b0}}}
                             - 32'(frac[FINE_BITS-1 -: COARSE_BITS]);
            end
        end

        always_ff @(posedge REF_CLK or posedge RESET)
        begin
            if (RESET)
            begin
                servo_latch      <= 32'h0000_0000;
                fine_servo_latch <= 32'h0000_0000;
            end
            else if (servo_event)
            begin
                servo_latch      <= coarse_pos;
                fine_servo_latch <= fine_pos;
            end
        end

        always_ff @(posedge REF_CLK or posedge RESET)
        begin
            if (RESET)
                phase_latch <= 32'h0000_0000;
            else if (phase_event)
                phase_latch <= coarse_pos;
        end

        always_ff @(posedge REF_CLK or posedge RESET)
        begin
            if (RESET)
            begin
                trigger_latch      <= 32'h0000_0000;
                fine_trigger_latch <= 32'h0000_0000;
            end
            else if (trig_event)
            begin
                trigger_latch      <= coarse_pos;
                fine_trigger_latch <= fine_pos;
            end
        end

        always_comb
        begin
            unique case (reg_sel)
                3'h0:    rd_word[ch] = {23'h000000, ctrl.arctangent_extension_enable,
                                        ctrl.fraction_source_select,
                                        ctrl.decode_control};
                3'h1:    rd_word[ch] = {28'h0000000, dir_up, filt_b, filt_a, fault};
                3'h2:    rd_word[ch] = servo_latch;
                3'h3:    rd_word[ch] = phase_latch;
                3'h4:    rd_word[ch] = trigger_latch;
                3'h5:    rd_word[ch] = fine_servo_latch;
                3'h6:    rd_word[ch] = fine_trigger_latch;
                default: rd_word[ch] = 32'h0000_0000;
            endcase
        end
    end
endmodule : quadrature_encoder_interface
`default_nettype wire

// >>> qei_checker.sv
`default_nettype none
module qei_checker
    import qei_pkg::*;
#(
    parameter int NCH = NUM_CHANNELS
)(
    // clock and reset
    input wire logic        REF_CLK,
    input wire logic        RESET,
    // apb
    input wire logic        PSEL,
    input wire logic        PENABLE,
    input wire logic        PWRITE,
    input wire logic [11:0] PADDR,
    input wire logic [31:0] PRDATA,
    input wire logic        PREADY,
    input wire logic        PSLVERR
);
    logic       acc;
    logic       rd;
    logic       hit;
    logic [4:0] off;

    assign acc = PSEL && PENABLE;
    assign rd  = acc && !PWRITE;
    assign off = PADDR[4:0];
    assign hit = PADDR[1:0] == 2'h0 && (PADDR == DIVIDERS_OFFSET
        || (PADDR >= CHANNEL_BASE && PADDR < CHANNEL_BASE + 12'(NCH * 32)
        && off <= FINE_TRIG_OFFSET));

    default clocking cb @(posedge REF_CLK);
    endclocking
    default disable iff (RESET);

    // ****
    // bus answer
    // ****
    a_ready_always: assert property (PREADY)
        else $error("ready dropped");
    a_err_in_access: assert property (PSLVERR |-> acc)
        else $error("error outside access");
    a_err_unmapped: assert property (acc && !hit |-> PSLVERR)
        else $error("unmapped not refused");
    a_err_mapped: assert property (acc && hit |-> !PSLVERR)
        else $error("mapped refused");
    a_bad_reads_zero: assert property (rd && !hit |-> PRDATA == 32'h0)
        else $error("unmapped read not zero");
    // read data only moves after a setup cycle, so latched values stay readable
    a_rdata_held: assert property (!(PSEL && !PENABLE) |=> $stable(PRDATA))
        else $error("read data moved");
    // ****
    // register fields
    // ****
    a_div_fields: assert property (rd && PADDR == DIVIDERS_OFFSET |-> PRDATA[31:8] == 24'h0)
        else $error("divider spare bits set");
    a_ctrl_fields: assert property (rd && hit && PADDR[11:8] == 4'h1
        && off == CONTROL_OFFSET |-> PRDATA[31:9] == 23'h0)
        else $error("control spare bits set");
    a_stat_fields: assert property (rd && hit && PADDR[11:8] == 4'h1
        && off == STATUS_OFFSET |-> PRDATA[31:4] == 28'h0)
        else $error("status spare bits set");
endmodule : qei_checker
`default_nettype wire

// >>> qei_encoder_model.sv
`default_nettype none
module qei_encoder_model
(
    // step timing
    input  wire logic clk,
    // encoder pins
    output var logic  a,
    output var logic  b,
    output var logic  trigger
);
    timeunit 1ns;
    timeprecision 1ns;

    initial
    begin
        a = 1'b0;
        b = 1'b0;
        trigger = 1'b0;
    end

    // ****
    // quadrature steps
    // ****
    // forward: a takes the inverse of b, so a leads
    task automatic step(input bit up, input int hold);
        @(posedge clk);
        if (a == b)
        begin
            if (up)
                a <= !a;
            else
                b <= !b;
        end
        else if (up)
            b <= a;
        else
            a <= b;
        repeat (hold) @(posedge clk);
    endtask : step

    // both lines in one step: an illegal jump of two states
    task automatic jump(input int hold);
        @(posedge clk);
        a <= !a;
        b <= !b;
        repeat (hold) @(posedge clk);
    endtask : jump

    task automatic pulse_trigger(input int hold);
        @(posedge clk);
        trigger <= 1'b1;
        repeat (hold) @(posedge clk);
        trigger <= 1'b0;
        repeat (hold) @(posedge clk);
    endtask : pulse_trigger
endmodule : qei_encoder_model
`default_nettype wire

// >>> tb.sv
`default_nettype none
`define CHK(got, exp) \
    begin \
        comparisons++; \
        if ((got) !== (exp)) \
        begin \
            failures++; \
            $display("BAD t=%0t got=%h exp=%h", $time, (got), (exp)); \
        end \
    end
module tb
    import qei_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;

    logic                   clk;
    logic                   rst;
    logic                   psel;
    logic                   penable;
    logic                   pwrite;
    logic [11:0]            paddr;
    logic [31:0]            pwdata;
    logic [31:0]            prdata;
    logic                   pready;
    logic                   pslverr;
    logic                   servo;
    logic                   phase;
    logic                   enc_a;
    logic                   enc_b;
    logic                   enc_t;
    channel_pins_t [3:0]    enc;
    logic [47:0]            atan;
    logic [31:0]            rdata;
    logic                   err;
    logic [23:0]            cnt;
    int                     failures;
    int                     comparisons;
    int                     cycles;

    // only channel 0 is exercised
    assign enc = {9'h000, enc_a, enc_b, enc_t};

    quadrature_encoder_interface #(.NCH(4)) u_dut (
        .REF_CLK(clk), .RESET(rst), .PSEL(psel), .PENABLE(penable),
        .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata),
        .PREADY(pready), .PSLVERR(pslverr), .SERVO_CLOCK(servo),
        .PHASE_CLOCK(phase), .ENCODER(enc), .ARCTANGENT_FRACTION(atan));

    qei_encoder_model u_enc (.clk(clk), .a(enc_a), .b(enc_b), .trigger(enc_t));

    // ****
    // bus and helpers
    // ****
    task automatic apb(input logic wr, input logic [11:0] addr, input logic [31:0] wd);
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= addr;
        pwdata <= wd;
        @(posedge clk);
        penable <= 1'b1;
        do
        begin
            @(posedge clk);
        end
        while (pready !== 1'b1);
        rdata = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    function automatic logic [11:0] ch(input logic [4:0] o);
        return CHANNEL_BASE | 12'(o);
    endfunction : ch

    task automatic expect_reg(input logic [11:0] addr, input logic [31:0] exp);
        apb(1'b0, addr, 32'h0);
        `CHK(rdata, exp)
    endtask : expect_reg

    task automatic move(input int n);
        repeat (n) u_enc.step(1'b1, 16);
        cnt = cnt + 24'(n);
    endtask : move

    task automatic pulse(input logic s, input logic p);
        @(posedge clk);
        servo <= s;
        phase <= p;
        repeat (4) @(posedge clk);
        servo <= 1'b0;
        phase <= 1'b0;
        repeat (6) @(posedge clk);
    endtask : pulse

    task automatic check_servo;
        expect_reg(ch(SERVO_OFFSET), {cnt, 8'h00});
        expect_reg(ch(FINE_SERVO_OFFSET), {cnt[19:0], 12'h000});
    endtask : check_servo

    // ****
    // scenarios
    // ****
    task automatic t_reset;
        expect_reg(DIVIDERS_OFFSET, 32'h00000045);
        expect_reg(ch(CONTROL_OFFSET), 32'h00000003);
        expect_reg(ch(SERVO_OFFSET), 32'h0);
        apb(1'b0, 12'h102, 32'h0);
        `CHK({err, rdata}, 33'h100000000)
        $display("t_reset done");
    endtask : t_reset

    task automatic t_divider;
        apb(1'b1, DIVIDERS_OFFSET, 32'h0000000F);
        expect_reg(DIVIDERS_OFFSET, 32'h0000000F);
        apb(1'b1, 12'h1FC, 32'h0000FFFF);
        `CHK(err, 1'b1)
        apb(1'b1, DIVIDERS_OFFSET, 32'h00000001);
        expect_reg(DIVIDERS_OFFSET, 32'h00000001);
        $display("t_divider done");
    endtask : t_divider

    task automatic t_x4;
        apb(1'b1, ch(CONTROL_OFFSET), 32'h00000013);
        move(10);
        pulse(1'b1, 1'b0);
        check_servo();
        $display("t_x4 done");
    endtask : t_x4

    task automatic t_sense;
        logic [23:0] held;
        held = cnt;
        apb(1'b1, ch(CONTROL_OFFSET), 32'h00000017);
        repeat (6) u_enc.step(1'b1, 16);
        cnt = cnt - 24'd6;
        pulse(1'b0, 1'b1);
        expect_reg(ch(PHASE_OFFSET), {cnt, 8'h00});
        expect_reg(ch(SERVO_OFFSET), {held, 8'h00});
        $display("t_sense done");
    endtask : t_sense

    task automatic t_modes;
        logic [31:0] ctl [3] = '{32'h12, 32'h11, 32'h10};
        int          gain [3] = '{4, 2, 0};
        for (int i = 0; i < 3; i++)
        begin
            apb(1'b1, ch(CONTROL_OFFSET), ctl[i]);
            repeat (8) u_enc.step(1'b1, 16);
            cnt = cnt + 24'(gain[i]);
            pulse(1'b1, 1'b0);
            check_servo();
        end
        $display("t_modes done");
    endtask : t_modes

    task automatic t_fault;
        apb(1'b1, ch(CONTROL_OFFSET), 32'h00000013);
        u_enc.jump(16);
        expect_reg(ch(STATUS_OFFSET), 32'h0000000F);
        `CHK(rdata[STAT_FAULT_BIT], 1'b1)
        pulse(1'b1, 1'b0);
        check_servo();
        apb(1'b1, ch(STATUS_OFFSET), 32'h00000001);
        apb(1'b0, ch(STATUS_OFFSET), 32'h0);
        `CHK(rdata[STAT_FAULT_BIT], 1'b0)
        $display("t_fault done");
    endtask : t_fault

    task automatic t_trigger;
        logic [23:0] held;
        held = cnt;
        move(4);
        u_enc.pulse_trigger(20);
        expect_reg(ch(TRIGGER_OFFSET), {cnt, 8'h00});
        expect_reg(ch(FINE_TRIG_OFFSET), {cnt[19:0], 12'h000});
        expect_reg(ch(SERVO_OFFSET), {held, 8'h00});
        $display("t_trigger done");
    endtask : t_trigger

    task automatic t_atan;
        apb(1'b1, ch(CONTROL_OFFSET), 32'h00000103);
        atan <= 48'h000000000ABC;
        expect_reg(ch(CONTROL_OFFSET), 32'h00000103);
        pulse(1'b1, 1'b0);
        apb(1'b0, ch(FINE_SERVO_OFFSET), 32'h0);
        `CHK(rdata, {cnt[19:0], 12'hABC})
        expect_reg(ch(SERVO_OFFSET), {cnt, 8'hAB});
        // encoder idle far longer than its last gap: timer fraction saturates
        apb(1'b1, ch(CONTROL_OFFSET), 32'h00000003);
        pulse(1'b1, 1'b0);
        expect_reg(ch(SERVO_OFFSET), {cnt, 8'hFF});
        $display("t_atan done");
    endtask : t_atan

    // ****
    // run control
    // ****
    task automatic end_of_test;
        $display("comparisons=%0d failures=%0d", comparisons, failures);
        if (failures == 0 && comparisons > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : end_of_test

    initial
    begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    // runs take about 1000 cycles, so this leaves wide headroom
    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 40000)
        begin
            failures++;
            end_of_test();
        end
    end

    initial
    begin
        {rst, psel, penable, pwrite, servo, phase} = 6'h20;
        {paddr, pwdata, atan, cnt} = '0;
        {failures, comparisons, cycles} = '0;
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        t_reset();
        t_divider();
        t_x4();
        t_sense();
        t_modes();
        t_fault();
        t_trigger();
        t_atan();
        end_of_test();
    end
endmodule : tb

bind quadrature_encoder_interface qei_checker #(.NCH(NCH)) u_chk (
    .REF_CLK(REF_CLK), .RESET(RESET), .PSEL(PSEL), .PENABLE(PENABLE),
    .PWRITE(PWRITE), .PADDR(PADDR), .PRDATA(PRDATA), .PREADY(PREADY),
    .PSLVERR(PSLVERR));
`default_nettype wire
